// file: logic/lar_defs.vh
// constants for the line auto-reclose control block
`ifndef LAR_DEFS_VH
`define LAR_DEFS_VH
`define LAR_AW 4
`define LAR_DW 16
// register offsets
`define LAR_REG_CTRL 4'h0
`define LAR_REG_START_EN 4'h1
`define LAR_REG_RECLAIM 4'h2
`define LAR_REG_MC_BLOCK 4'h3
`define LAR_REG_START_MON 4'h4
`define LAR_REG_CB_MON 4'h5
`define LAR_REG_DEAD_EXT 4'h6
`define LAR_REG_REMOTE_DLY 4'h7
`define LAR_REG_DEAD_3P 4'h8
`define LAR_REG_DEAD_C0 4'h9
`define LAR_REG_CB_CHK 4'hD
`define LAR_REG_STATUS 4'hE
// control fields
`define LAR_CTRL_ON 0
`define LAR_CTRL_FIRST_CHK 1
`define LAR_CTRL_EV_TRIP 2
`define LAR_CTRL_EV_3P 3
`define LAR_CTRL_REMOTE_ADT 4
`define LAR_CTRL_CYC_LSB 5
`define LAR_CTRL_RST 16'h0000
// timer unit: 1 ms at 40 MHz
`define LAR_TICK_NS 1000000
`define LAR_CLK_NS 25
`define LAR_TICK_CYC (`LAR_TICK_NS / `LAR_CLK_NS)
`define LAR_TIME_INF 16'hFFFF
`define LAR_MAX_CYCLES 8
`endif

// file: logic/lar_timer.v
// millisecond down-counter with load, run and expiry flag
`timescale 1ns/100ps
`include "lar_defs.vh"
module lar_timer (
   input wire clk_i,
   input wire rstn_i,
   input wire ce_i,
   input wire tick_i,
   input wire load_i,
   input wire [15:0] value_i,
   input wire run_i,
   output reg done_o
);
   reg [15:0] count;
   // all-ones at load means never expire; latched so a changing input mux cannot stall a run
   reg inf;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count <= 16'h0000;
         done_o <= 1'b0;
         inf <= 1'b0;
      end else if (ce_i) begin
         if (load_i) begin
            count <= value_i;
            done_o <= (value_i == 16'h0000);
            inf <= (value_i == `LAR_TIME_INF);
         end else if (run_i && tick_i && count != 16'h0000 && !inf) begin
            count <= count - 16'h0001;
            done_o <= (count == 16'h0001);
         end
      end
   end
endmodule

// file: logic/lar_core.v
// automatic reclose sequencer with register port and timers
//
// Behaviour
// [RL1] eight cycles; cycle four settings reused after
// [RL2] excluded build: no logic, three-pole trips
// [RL3] run-time on/off switch for reclose
// [RL4] optional breaker-ready check at first trip
// [RL5] per-cycle breaker-ready check before reclose
// [RL6] breaker-ready monitor expiry blocks dynamically
// [RL7] dead time extension capped; infinity unlimited
// [RL8] reset only after full reclaim time
// [RL9] retrip in reclaim: next cycle or lockout
// [RL10] fault after manual close: final trip
// [RL11] pickup option: pickup in dead time evolves
// [RL12] trip option: trip in dead time evolves
// [RL13] pickup-less external trips evolve by trip
// [RL14] blocking reaction: no reclose after evolving
// [RL15] three-pole reaction starts three-pole dead time
// [RL16] adaptive mode skips evolving fault handling
// [RL17] breaker must open or trip reset within start monitor time
// [RL18] remote close delayed, only toward adaptive end
// [RL19] per-function enables for reclose start
// [RL20] dynamic block drops pending close
`timescale 1ns/100ps
`include "lar_defs.vh"
module lar_core #(
   parameter AR_PRESENT = 1,
   parameter ADAPTIVE_MODE = 0
) (
   input wire clk_i,
   input wire rstn_i,
   input wire ce_i,
   input wire [3:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   input wire [5:0] func_trip_i,
   input wire [5:0] func_pickup_i,
   input wire ext_trip_i,
   input wire ext_pickup_i,
   input wire breaker_ready_input_i,
   input wire breaker_open_i,
   input wire manual_close_i,
   output reg close_cmd_o,
   output reg remote_close_o,
   output reg trip_3pole_o,
   output reg final_trip_o,
   output reg ar_blocked_o,
   output reg ar_busy_o
);
   localparam ST_IDLE = 3'd0;
   localparam ST_OPEN = 3'd1;
   localparam ST_DEAD = 3'd2;
   localparam ST_EXT = 3'd3;
   localparam ST_RECLAIM = 3'd4;
   localparam ST_LOCK = 3'd5;
   localparam ST_MCBLK = 3'd6;

   reg [15:0] ctrl;
   reg [5:0] start_by_enable;
   reg [15:0] reclaim_time;
   reg [15:0] manual_close_block_time;
   reg [15:0] start_mon_time;
   reg [15:0] breaker_ready_monitor_time;
   reg [15:0] dead_time_extension_limit;
   reg [15:0] remote_delay_time;
   reg [15:0] dead_3p_time;
   reg [15:0] dead_cyc [0:3];
   reg [3:0] cb_check_cycle;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [3:0] cycle;
   reg evolving;
   reg use_3p_dead;
   reg remote_pend;
   reg [15:0] tick_cnt;
   reg tick;
   reg trip_d;
   reg pickup_d;
   integer k;

   wire ar_on = (AR_PRESENT != 0) && ctrl[`LAR_CTRL_ON]; // RL2 RL3
   wire first_trip_breaker_check = ctrl[`LAR_CTRL_FIRST_CHK];
   wire evolving_fault_detect_select = ctrl[`LAR_CTRL_EV_TRIP];
   wire evolving_fault_reaction = ctrl[`LAR_CTRL_EV_3P];
   wire [3:0] max_cycles = ctrl[`LAR_CTRL_CYC_LSB+3:`LAR_CTRL_CYC_LSB];
   wire adaptive_dead_time_mode = (ADAPTIVE_MODE != 0);

   // cycle index into the four parameter sets
   function [1:0] cyc_set;
      input [3:0] c;
      begin
         cyc_set = (c >= 4'd4) ? 2'd3 : c[1:0]; // RL1
      end
   endfunction

   wire start_trip = |(func_trip_i & start_by_enable); // RL19
   wire any_trip = (|func_trip_i) | ext_trip_i;
   wire any_pickup = (|func_pickup_i) | ext_pickup_i;
   wire trip_rise = any_trip & ~trip_d;
   wire pickup_rise = any_pickup & ~pickup_d;
   // only a fresh event counts: the trip that opened the breaker may still stand in the dead time
   // externals without pickup only show up through their trip
   wire ev_seen = evolving_fault_detect_select ? trip_rise : (pickup_rise | trip_rise); // RL11 RL12 RL13
   wire ev_now = (state == ST_DEAD) && ev_seen && !adaptive_dead_time_mode; // RL16
   wire ev_any = evolving || ev_now;
   wire more_cycles = (cycle + 4'd1 < max_cycles) && (cycle + 4'd1 < 4'd8); // RL1 RL9
   wire cb_chk_now = cb_check_cycle[cyc_set(cycle)];

   // timer controls
   reg t_main_load;
   reg [15:0] t_main_val;
   reg t_mon_load;
   reg [15:0] t_mon_val;
   wire t_main_done;
   wire t_mon_done;
   wire t_rem_done;
   wire t_ext_done;
   // 1 ms tick period; only the low half is needed by the counter
   wire [31:0] tick_reload = `LAR_TICK_CYC - 32'h0000_0001;

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (ce_i) begin
         tick <= (tick_cnt == 16'h0000);
         tick_cnt <= (tick_cnt == 16'h0000) ? tick_reload[15:0] : tick_cnt - 16'h0001;
      end
   end

   // main timer: dead, reclaim, manual close block
   lar_timer u_main (
      .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .tick_i(tick),
      .load_i(t_main_load), .value_i(t_main_val), .run_i(1'b1), .done_o(t_main_done)
   );
   // monitor timer: start monitor and breaker-ready monitor
   lar_timer u_mon (
      .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .tick_i(tick),
      .load_i(t_mon_load), .value_i(t_mon_val), .run_i(1'b1), .done_o(t_mon_done)
   );
   // extension timer: armed when the dead time runs out with the breaker not ready
   lar_timer u_ext (
      .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .tick_i(tick),
      .load_i(state == ST_DEAD && next_state == ST_EXT), .value_i(dead_time_extension_limit),
      .run_i(state == ST_EXT), .done_o(t_ext_done)
   );
   lar_timer u_rem (
      .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .tick_i(tick),
      .load_i(close_cmd_o), .value_i(remote_delay_time), .run_i(remote_pend), .done_o(t_rem_done)
   );

   always @* begin
      next_state = state;
      t_main_load = 1'b0;
      t_main_val = dead_cyc[cyc_set(cycle)];
      t_mon_load = 1'b0;
      t_mon_val = start_mon_time;
      case (state)
         ST_IDLE: begin
            if (ar_on && manual_close_i && manual_close_block_time != 16'h0000) begin
               next_state = ST_MCBLK; // RL10
               t_main_load = 1'b1;
               t_main_val = manual_close_block_time;
            end else if (ar_on && start_trip && !(first_trip_breaker_check && !breaker_ready_input_i)) begin
               next_state = ST_OPEN; // RL4
               t_mon_load = 1'b1;
            end else if (ar_on && start_trip) begin
               next_state = ST_LOCK;
            end
         end
         ST_MCBLK: begin
            if (any_pickup | any_trip) begin
               next_state = ST_LOCK; // RL10
            end else if (t_main_done) begin
               next_state = ST_IDLE;
            end
         end
         ST_OPEN: begin
            if (breaker_open_i || !any_trip) begin
               next_state = ST_DEAD; // RL17
               t_main_load = 1'b1;
               t_main_val = use_3p_dead ? dead_3p_time : dead_cyc[cyc_set(cycle)]; // RL15
               t_mon_load = 1'b1;
               t_mon_val = breaker_ready_monitor_time;
            end else if (t_mon_done) begin
               next_state = ST_LOCK; // RL17
            end
         end
         ST_DEAD: begin
            if (ev_any && !evolving_fault_reaction) begin
               next_state = ST_LOCK; // RL14 RL16
            end else if (ev_any && any_trip) begin
               next_state = ST_OPEN; // RL15
               t_mon_load = 1'b1;
            end else if (t_mon_done && !breaker_ready_input_i && cb_chk_now) begin
               next_state = ST_LOCK; // RL6
            end else if (t_main_done) begin
               next_state = (cb_chk_now && !breaker_ready_input_i) ? ST_EXT : ST_RECLAIM; // RL5
               t_main_load = !(cb_chk_now && !breaker_ready_input_i);
               t_main_val = reclaim_time;
            end
         end
         ST_EXT: begin
            if (breaker_ready_input_i) begin
               next_state = ST_RECLAIM;
               t_main_load = 1'b1;
               t_main_val = reclaim_time;
            end else if (t_ext_done || t_mon_done) begin
               next_state = ST_LOCK; // RL6 RL7
            end
         end
         ST_RECLAIM: begin
            if (start_trip) begin
               next_state = more_cycles ? ST_OPEN : ST_LOCK; // RL9
               t_mon_load = more_cycles;
            end else if (t_main_done) begin
               next_state = ST_IDLE; // RL8
            end
         end
         ST_LOCK: begin
            // wait for quiescence before rearming
            if (!any_trip && !any_pickup) begin
               next_state = ST_IDLE; // RL20
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= ST_IDLE;
         cycle <= 4'h0;
         evolving <= 1'b0;
         use_3p_dead <= 1'b0;
         remote_pend <= 1'b0;
         trip_d <= 1'b0;
         pickup_d <= 1'b0;
         close_cmd_o <= 1'b0;
         remote_close_o <= 1'b0;
         trip_3pole_o <= 1'b0;
         final_trip_o <= 1'b0;
         ar_blocked_o <= 1'b0;
         ar_busy_o <= 1'b0;
      end else if (ce_i) begin
         trip_d <= any_trip;
         pickup_d <= any_pickup;
         state <= next_state;
         // cleared on leaving the dead time so a three-pole restart does not loop on it
         if (next_state != ST_DEAD) begin
            evolving <= 1'b0;
         end else if (ev_now) begin
            evolving <= 1'b1; // RL11 RL12
         end
         if (state == ST_DEAD && next_state == ST_OPEN) begin
            use_3p_dead <= 1'b1; // RL15
         end else if (next_state != ST_DEAD) begin
            use_3p_dead <= (state == ST_OPEN) ? use_3p_dead : 1'b0;
         end
         if (state == ST_RECLAIM && next_state == ST_OPEN) begin
            cycle <= cycle + 4'd1;
         end else if (next_state == ST_IDLE) begin
            cycle <= 4'h0;
         end
         close_cmd_o <= (state == ST_DEAD || state == ST_EXT) && next_state == ST_RECLAIM; // RL20
         if (close_cmd_o && ctrl[`LAR_CTRL_REMOTE_ADT]) begin
            remote_pend <= 1'b1; // RL18
         end else if (remote_pend && (t_rem_done || next_state == ST_LOCK)) begin
            remote_pend <= 1'b0;
         end
         remote_close_o <= remote_pend && t_rem_done && next_state != ST_LOCK; // RL18
         // lockout trips are final and therefore three-pole
         trip_3pole_o <= any_trip && (!ar_on || use_3p_dead || next_state == ST_LOCK); // RL2 RL10
         final_trip_o <= (next_state == ST_LOCK) && any_trip; // RL10
         ar_blocked_o <= (state == ST_LOCK);
         ar_busy_o <= (state != ST_IDLE);
      end
   end

   // register port
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl <= `LAR_CTRL_RST;
         start_by_enable <= 6'h00;
         reclaim_time <= 16'h0000;
         manual_close_block_time <= 16'h0000;
         start_mon_time <= 16'h0000;
         breaker_ready_monitor_time <= 16'h0000;
         dead_time_extension_limit <= `LAR_TIME_INF;
         remote_delay_time <= 16'h0000;
         dead_3p_time <= 16'h0000;
         cb_check_cycle <= 4'h0;
         for (k = 0; k < 4; k = k + 1) begin
            dead_cyc[k] <= 16'h0000;
         end
         rdata_o <= 16'h0000;
      end else if (ce_i) begin
         if (wr_i) begin
            case (addr_i)
               `LAR_REG_CTRL: ctrl <= wdata_i;
               `LAR_REG_START_EN: start_by_enable <= wdata_i[5:0];
               `LAR_REG_RECLAIM: reclaim_time <= wdata_i;
               `LAR_REG_MC_BLOCK: manual_close_block_time <= wdata_i;
               `LAR_REG_START_MON: start_mon_time <= wdata_i;
               `LAR_REG_CB_MON: breaker_ready_monitor_time <= wdata_i;
               `LAR_REG_DEAD_EXT: dead_time_extension_limit <= wdata_i;
               `LAR_REG_REMOTE_DLY: remote_delay_time <= wdata_i;
               `LAR_REG_DEAD_3P: dead_3p_time <= wdata_i;
               `LAR_REG_CB_CHK: cb_check_cycle <= wdata_i[3:0];
               default: begin
                  if (addr_i >= `LAR_REG_DEAD_C0 && addr_i < `LAR_REG_CB_CHK) begin
                     dead_cyc[addr_i[1:0] - 2'd1] <= wdata_i;
                  end
               end
            endcase
         end
         rdata_o <= 16'h0000;
         if (rd_i) begin
            case (addr_i)
               `LAR_REG_CTRL: rdata_o <= ctrl;
               `LAR_REG_START_EN: rdata_o <= {10'h000, start_by_enable};
               `LAR_REG_RECLAIM: rdata_o <= reclaim_time;
               `LAR_REG_MC_BLOCK: rdata_o <= manual_close_block_time;
               `LAR_REG_START_MON: rdata_o <= start_mon_time;
               `LAR_REG_CB_MON: rdata_o <= breaker_ready_monitor_time;
               `LAR_REG_DEAD_EXT: rdata_o <= dead_time_extension_limit;
               `LAR_REG_REMOTE_DLY: rdata_o <= remote_delay_time;
               `LAR_REG_DEAD_3P: rdata_o <= dead_3p_time;
               `LAR_REG_CB_CHK: rdata_o <= {12'h000, cb_check_cycle};
               `LAR_REG_STATUS: rdata_o <= {5'h00, evolving, use_3p_dead, remote_pend, cycle, 1'b0, state};
               default: begin
                  if (addr_i >= `LAR_REG_DEAD_C0 && addr_i < `LAR_REG_CB_CHK) begin
                     rdata_o <= dead_cyc[addr_i[1:0] - 2'd1];
                  end
               end
            endcase
         end
      end
   end
endmodule

// file: bench/lar_breaker_model.sv
// breaker model: opens on a held trip, closes on command, ready recovers after a close
`timescale 1ns/100ps
module lar_breaker_model #(
   parameter OPEN_DLY = 3,
   parameter RECOVER = 8
) (
   input wire clk_i,
   input wire rstn_i,
   input wire trip_i,
   input wire close_i,
   input wire stuck_i,
   input wire ready_en_i,
   output reg open_o,
   output wire ready_o
);
   reg [7:0] tcnt;
   reg [7:0] rcnt;
   // stored energy is spent by each close, so ready dips until the spring recharges
   assign ready_o = ready_en_i && (rcnt >= RECOVER);
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         open_o <= 1'b0;
         tcnt <= 8'h00;
         rcnt <= 8'hFF;
      end else begin
         tcnt <= trip_i ? tcnt + 8'h01 : 8'h00;
         if (rcnt != 8'hFF)
            rcnt <= rcnt + 8'h01;
         if (close_i) begin
            open_o <= 1'b0;
            rcnt <= 8'h00;
         end else if (tcnt == OPEN_DLY && !stuck_i)
            open_o <= 1'b1;
      end
   end
endmodule

// file: bench/lar_core_properties.sv
// port checker for the reclose sequencer
`timescale 1ns/100ps
module lar_core_properties #(
   parameter AR_PRESENT = 1
) (
   input wire clk_i,
   input wire rstn_i,
   input wire ce_i,
   input wire [3:0] addr_i,
   input wire rd_i,
   input wire [15:0] rdata_o,
   input wire close_cmd_o,
   input wire remote_close_o,
   input wire final_trip_o,
   input wire trip_3pole_o,
   input wire ar_blocked_o,
   input wire ar_busy_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   AST_CLOSE_PULSE: assert property (close_cmd_o |=> !close_cmd_o)
      else $error("close command longer than one cycle");
   AST_REMOTE_PULSE: assert property (remote_close_o |=> !remote_close_o)
      else $error("remote close longer than one cycle");
   AST_BLOCK_NO_CLOSE: assert property (ar_blocked_o |-> !close_cmd_o)
      else $error("close issued while blocked");
   AST_FINAL_NO_CLOSE: assert property (final_trip_o |-> !close_cmd_o && !$rose(remote_close_o))
      else $error("close issued with final trip");
   AST_FINAL_3P: assert property (final_trip_o |-> trip_3pole_o)
      else $error("final trip not three-pole");
   AST_CLOSE_BUSY: assert property (close_cmd_o |-> $past(ar_busy_o) && ar_busy_o)
      else $error("close issued outside a sequence");
   AST_BLOCK_BUSY: assert property (ar_blocked_o |-> ar_busy_o)
      else $error("blocked without busy");
   AST_EXCLUDED: assert property (AR_PRESENT == 0 |-> !ar_busy_o && !close_cmd_o)
      else $error("reclose activity in excluded build");
   AST_RDATA_IDLE: assert property ($past(ce_i) && !$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data outside read slot");
   AST_UNMAPPED: assert property (rd_i && ce_i && addr_i == 4'hF |=> rdata_o == 16'h0000)
      else $error("unmapped index read nonzero");
   cover property (close_cmd_o);
   cover property (final_trip_o);
   cover property (ar_blocked_o && !final_trip_o);
endmodule
bind lar_core lar_core_properties #(.AR_PRESENT(AR_PRESENT)) u_props (.clk_i(clk_i), .rstn_i(rstn_i),
   .ce_i(ce_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .close_cmd_o(close_cmd_o),
   .remote_close_o(remote_close_o), .final_trip_o(final_trip_o), .trip_3pole_o(trip_3pole_o),
   .ar_blocked_o(ar_blocked_o),
   .ar_busy_o(ar_busy_o));

// file: bench/tb.sv
// self-checking bench for the reclose sequencer
`timescale 1ns/100ps
`include "lar_defs.vh"
module tb;
   reg clk_i = 1'b0;
   reg rstn_i = 1'b0;
   reg ce_i = 1'b1;
   reg [3:0] addr_i = 4'h0;
   reg [15:0] wdata_i = 16'h0000;
   reg wr_i = 1'b0;
   reg rd_i = 1'b0;
   reg [5:0] func_trip_i = 6'h00;
   reg manual_close_i = 1'b0;
   reg stuck = 1'b0;
   reg ready_en = 1'b1;
   wire [15:0] rdata_o;
   wire ready, brk_open, close_cmd_o, remote_close_o, trip_3pole_o, final_trip_o, ar_blocked_o, ar_busy_o;
   integer mismatches = 0;
   integer checked = 0;
   integer closes = 0;
   integer remotes = 0;
   integer base;
   lar_core DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .func_trip_i(func_trip_i), .func_pickup_i(6'h00), .ext_trip_i(1'b0),
      .ext_pickup_i(1'b0), .breaker_ready_input_i(ready), .breaker_open_i(brk_open),
      .manual_close_i(manual_close_i), .close_cmd_o(close_cmd_o), .remote_close_o(remote_close_o),
      .trip_3pole_o(trip_3pole_o), .final_trip_o(final_trip_o), .ar_blocked_o(ar_blocked_o),
      .ar_busy_o(ar_busy_o));
   lar_breaker_model u_brk (.clk_i(clk_i), .rstn_i(rstn_i), .trip_i(|func_trip_i || trip_3pole_o),
      .close_i(close_cmd_o || manual_close_i), .stuck_i(stuck), .ready_en_i(ready_en), .open_o(brk_open),
      .ready_o(ready));
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (close_cmd_o)
         closes <= closes + 1;
      if (remote_close_o)
         remotes <= remotes + 1;
   end
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", checked, mismatches);
         if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [15:0] g, input [15:0] e);
      begin
         checked = checked + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task chk1(input g, input e);
      chk({15'h0000, g}, {15'h0000, e});
   endtask
   // which: 0 close, 1 final trip, 2 blocked, 3 idle
   task wait_on(input integer which, input integer lim);
      integer n;
      reg hit;
      begin
         n = 0;
         hit = 1'b0;
         while (hit !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            #1;
            n = n + 1;
            case (which)
               0: hit = close_cmd_o;
               1: hit = final_trip_o;
               2: hit = ar_blocked_o;
               default: hit = !ar_busy_o;
            endcase
         end
         if (hit !== 1'b1) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, hit, 1'b1);
            print_verdict;
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      begin
         @(posedge clk_i);
         wr_i <= 1'b1;
         addr_i <= a;
         wdata_i <= d;
         @(posedge clk_i);
         wr_i <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [15:0] e);
      begin
         @(posedge clk_i);
         rd_i <= 1'b1;
         addr_i <= a;
         @(posedge clk_i);
         rd_i <= 1'b0;
         #1;
         chk(rdata_o, e);
      end
   endtask
   task trip_burst(input [5:0] b);
      begin
         @(posedge clk_i);
         func_trip_i <= b;
         repeat (20) @(posedge clk_i);
         func_trip_i <= 6'h00;
         repeat (2) @(posedge clk_i);
         #1;
      end
   endtask
   task close_by_hand;
      begin
         @(posedge clk_i);
         manual_close_i <= 1'b1;
         @(posedge clk_i);
         manual_close_i <= 1'b0;
         repeat (20) @(posedge clk_i);
      end
   endtask
   task t_regs;
      begin
         rd(`LAR_REG_CTRL, `LAR_CTRL_RST);
         rd(`LAR_REG_DEAD_EXT, `LAR_TIME_INF);
         wr(4'hF, 16'h1234);
         rd(4'hF, 16'h0000);
         wr(`LAR_REG_START_EN, 16'h002A);
         ce_i <= 1'b0;
         wr(`LAR_REG_START_EN, 16'h0015);
         ce_i <= 1'b1;
         rd(`LAR_REG_START_EN, 16'h002A);
         $display("test regs done");
      end
   endtask
   task t_no_start;
      begin
         @(posedge clk_i);
         ready_en <= 1'b0;
         wr(`LAR_REG_CTRL, 16'h0023);
         wr(`LAR_REG_START_EN, 16'h003F);
         trip_burst(6'h01);
         chk1(ar_busy_o, 1'b0);
         @(posedge clk_i);
         ready_en <= 1'b1;
         wr(`LAR_REG_CTRL, 16'h0020);
         trip_burst(6'h01);
         chk1(ar_busy_o, 1'b0);
         wr(`LAR_REG_CTRL, 16'h0021);
         wr(`LAR_REG_START_EN, 16'h0020);
         trip_burst(6'h01);
         chk1(ar_busy_o, 1'b0);
         $display("test no start done");
      end
   endtask
   task t_cycle;
      begin
         wr(`LAR_REG_MC_BLOCK, 16'h0000);
         close_by_hand;
         wr(`LAR_REG_CTRL, 16'h0031);
         wr(`LAR_REG_DEAD_C0, 16'h0001);
         wr(`LAR_REG_RECLAIM, 16'h0003);
         wr(`LAR_REG_START_MON, 16'h0003);
         wr(`LAR_REG_REMOTE_DLY, 16'h0000);
         base = closes;
         trip_burst(6'h20);
         chk1(ar_busy_o, 1'b1);
         wait_on(0, `LAR_TICK_CYC + 50);
         repeat (50) @(posedge clk_i);
         func_trip_i <= 6'h20;
         wait_on(2, 200);
         chk1(final_trip_o, 1'b1);
         chk(closes - base, 16'h0001);
         chk(remotes, 16'h0001);
         @(posedge clk_i);
         func_trip_i <= 6'h00;
         wait_on(3, 500);
         $display("test cycle done");
      end
   endtask
   task t_manual;
      begin
         wr(`LAR_REG_CTRL, 16'h0041);
         wr(`LAR_REG_MC_BLOCK, 16'h0002);
         base = closes;
         close_by_hand;
         func_trip_i <= 6'h20;
         wait_on(1, 200);
         chk1(trip_3pole_o, 1'b1);
         chk(closes - base, 16'h0000);
         @(posedge clk_i);
         func_trip_i <= 6'h00;
         wait_on(3, 500);
         $display("test manual close done");
      end
   endtask
   task t_start_mon;
      begin
         wr(`LAR_REG_MC_BLOCK, 16'h0000);
         close_by_hand;
         wr(`LAR_REG_CTRL, 16'h0021);
         wr(`LAR_REG_START_MON, 16'h0001);
         base = closes;
         stuck <= 1'b1;
         @(posedge clk_i);
         func_trip_i <= 6'h20;
         wait_on(2, `LAR_TICK_CYC + 50);
         chk1(final_trip_o, 1'b1);
         chk(closes - base, 16'h0000);
         @(posedge clk_i);
         func_trip_i <= 6'h00;
         stuck <= 1'b0;
         wait_on(3, 500);
         $display("test start monitor done");
      end
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      t_regs;
      t_no_start;
      t_cycle;
      t_manual;
      t_start_mon;
      print_verdict;
   end
endmodule
